// ==== src/ext_edge_and_periph_irq_logic.sv ====
// Interrupt request, enable, edge selection and vectoring logic with context shadow.
//
// Contract
// - Qualifying pin edge sets pin flag only while the pin enable is 1.
// - Pin edge with pin enable 0 leaves the pin flag unchanged.
// - Taken pin requests vector to 0x0009 (pin a) or 0x000A (pin b).
// - Matching pin edge during power-down is latched and served first after wake.
// - Pin b edge select bits 3:2: 01 rise, 10 fall, 11 both, 00 reserved.
// - Pin a edge select bits 1:0: 01 rise, 10 fall, 11 both, 00 reserved.
// - Flags stay set until software writes 0 or their source is taken; single-bit clear per flag.
// - Basic timer overflow sets its flag regardless of enable; vector 0x0B.
// - Basic timer vectors only when its enable is 1.
// - Timer a overflow sets flag regardless of enable; vectors 0x0C when enabled.
// - Timer a flag set while disabled never vectors after later enable.
// - Timer b overflow sets flag regardless of enable; vectors 0x0D when enabled.
// - Timer b flag set while disabled never vectors after later enable.
// - Timer c overflow sets flag regardless of enable; vectors 0x0E when enabled.
// - Timer c flag set while disabled never vectors after later enable.
// - Wide timer overflow sets flag regardless of enable; vector 0x0F.
// - Wide timer vectors only when its enable is 1.
// - Conversion end sets flag regardless of enable; vectors 0x10 when enabled.
// - Converter flag set while disabled never vectors after later enable.
// - Nothing vectors without global enable; each take adds one stack level.
// - Accumulator and work registers saved to shadow before vector load.
// - Return from interrupt reloads accumulator and work registers from shadow.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ext_edge_and_periph_irq_logic (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    ext_irq_pin_a,
    input  wire logic                    ext_irq_pin_b,
    input  wire logic                    power_down,
    input  wire irq_pkg::periph_events_t events,
    input  wire irq_pkg::reg_req_t       reg_req,
    output logic [7:0]                   reg_rdata,
    input  wire logic                    return_from_irq_instr,
    input  wire logic [7:0]              acc_in,
    input  wire logic [127:0]            work_regs_in,
    output irq_pkg::vec_out_t            vec_out,
    output logic                         stack_push,
    output logic                         restore_valid,
    output logic [7:0]                   acc_restore,
    output logic [127:0]                 work_regs_restore,
    output logic                         wake_request
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        unique case (irq_pkg::edge_sel_t'(sel))
            irq_pkg::EDGE_RISING:   edge_hit = rise;
            irq_pkg::EDGE_FALLING:  edge_hit = fall;
            irq_pkg::EDGE_BOTH:     edge_hit = rise | fall;
            irq_pkg::EDGE_RESERVED: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    function automatic logic [15:0] vec_of(input logic [2:0] src);
        unique case (src)
            3'h0: vec_of = irq_pkg::VEC_PIN_A;
            3'h1: vec_of = irq_pkg::VEC_PIN_B;
            3'h2: vec_of = irq_pkg::VEC_BASIC;
            3'h3: vec_of = irq_pkg::VEC_TMR_A;
            3'h4: vec_of = irq_pkg::VEC_TMR_B;
            3'h5: vec_of = irq_pkg::VEC_TMR_C;
            3'h6: vec_of = irq_pkg::VEC_WIDE;
            3'h7: vec_of = irq_pkg::VEC_CONV;
        endcase
    endfunction : vec_of

    // ****************************************
    // Registers
    // ****************************************
    logic [3:0]  edge_sel_r;
    logic [7:0]  enable_r;
    logic [7:0]  flags_r;
    logic [7:0]  flags_nxt;
    logic [7:0]  armed_r;
    logic [7:0]  armed_nxt;
    logic        global_r;
    logic        in_service_r;
    logic [1:0]  sync_a_r;
    logic [1:0]  sync_b_r;
    logic        prev_a_r;
    logic        prev_b_r;
    logic [7:0]  set_evt;
    logic [7:0]  eligible;
    logic        any_eligible;
    logic [2:0]  win_src;
    logic        wr_flags;
    logic        take;
    logic [2:0]  win_r;
    irq_pkg::irq_state_t state_r;
    logic [7:0]   acc_shadow_r;
    logic [127:0] work_shadow_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a_r <= 2'b00;
            sync_b_r <= 2'b00;
            prev_a_r <= 1'b0;
            prev_b_r <= 1'b0;
        end else begin
            sync_a_r <= {sync_a_r[0], ext_irq_pin_a};
            sync_b_r <= {sync_b_r[0], ext_irq_pin_b};
            prev_a_r <= sync_a_r[1];
            prev_b_r <= sync_b_r[1];
        end
    end

    always_comb begin
        set_evt = 8'h00;
        // Pin a gated by its enable.
        set_evt[irq_pkg::SRC_PIN_A] = enable_r[irq_pkg::SRC_PIN_A]
                                    & edge_hit(edge_sel_r[1:0], prev_a_r, sync_a_r[1]);
        set_evt[irq_pkg::SRC_PIN_B] = enable_r[irq_pkg::SRC_PIN_B]
                                    & edge_hit(edge_sel_r[3:2], prev_b_r, sync_b_r[1]);
        set_evt[irq_pkg::SRC_BASIC] = events.basic_timer_ovf;
        set_evt[irq_pkg::SRC_TMR_A] = events.tmr_a_ovf;
        set_evt[irq_pkg::SRC_TMR_B] = events.tmr_b_ovf;
        set_evt[irq_pkg::SRC_TMR_C] = events.tmr_c_ovf;
        set_evt[irq_pkg::SRC_WIDE]  = events.wide_timer_ovf;
        set_evt[irq_pkg::SRC_CONV]  = events.converter_done;
    end

    assign wr_flags = reg_req.wr && (reg_req.addr == irq_pkg::ADDR_FLAGS);

    // Flags cleared by software or by the take of their source; a new event wins over the clear.
    always_comb begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = reg_req.wdata;
        end
        if (take) begin
            flags_nxt[win_r] = 1'b0;
        end
        flags_nxt = flags_nxt | set_evt;
    end

    // A flag only vectors if its enable was already 1 when the event hit, so
    // enabling late never fires a stale flag.
    // Stale timer a flag blocked.
    always_comb begin
        armed_nxt = armed_r & flags_nxt & enable_r;
        armed_nxt = armed_nxt | (set_evt & enable_r);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r <= irq_pkg::FLAGS_RESET;
            armed_r <= irq_pkg::FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
            armed_r <= armed_nxt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            edge_sel_r <= irq_pkg::EDGE_SEL_RESET;
            enable_r   <= irq_pkg::ENABLE_RESET;
            global_r   <= 1'b0;
        end else if (reg_req.wr) begin
            unique case (reg_req.addr)
                irq_pkg::ADDR_EDGE_SEL: edge_sel_r <= reg_req.wdata[3:0];
                irq_pkg::ADDR_ENABLES:  enable_r   <= reg_req.wdata;
                irq_pkg::ADDR_GLOBAL:   global_r   <= reg_req.wdata[irq_pkg::GLOBAL_BIT];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Arbitration and vectoring
    // ****************************************
    // Basic timer needs enable.
    assign eligible     = flags_r & armed_r & enable_r & {8{global_r}};
    assign any_eligible = |eligible;

    always_comb begin
        win_src = 3'h0;
        for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                win_src = 3'(i);
            end
        end
    end

    // Wake latch: the edge already sits in the flag; wake asks the core
    // to resume so that service follows first.
    assign wake_request = power_down & |(set_evt[1:0] | (flags_r[1:0] & armed_r[1:0]));

    // Nested service is not supported: one shadow set exists.
    assign take = (state_r == irq_pkg::ST_SAVE);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r      <= irq_pkg::ST_IDLE;
            in_service_r <= 1'b0;
        end else begin
            unique case (state_r)
                irq_pkg::ST_IDLE: begin
                    if (any_eligible && !in_service_r && !power_down) begin
                        state_r <= irq_pkg::ST_SAVE;
                    end
                end
                irq_pkg::ST_SAVE: begin
                    state_r      <= irq_pkg::ST_SERVICE;
                    in_service_r <= 1'b1;
                end
                irq_pkg::ST_SERVICE: begin
                    if (return_from_irq_instr) begin
                        state_r      <= irq_pkg::ST_IDLE;
                        in_service_r <= 1'b0;
                    end
                end
                default: state_r <= irq_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_shadow_r  <= irq_pkg::ZERO_BYTE;
            work_shadow_r <= '0;
            win_r         <= 3'h0;
        end else if (state_r == irq_pkg::ST_IDLE && any_eligible && !in_service_r
                     && !power_down) begin
            acc_shadow_r  <= acc_in;
            work_shadow_r <= work_regs_in;
            // The winner is frozen at the decision edge, so a flag cleared in
            // the save cycle can never turn into a vector for an idle source.
            win_r         <= win_src;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vec_out    <= '0;
            stack_push <= 1'b0;
        end else begin
            vec_out.take   <= take;
            vec_out.vector <= take ? vec_of(win_r) : irq_pkg::VEC_NONE;
            vec_out.source <= take ? win_r : 3'h0;
            stack_push     <= take;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            restore_valid     <= 1'b0;
            acc_restore       <= irq_pkg::ZERO_BYTE;
            work_regs_restore <= '0;
        end else begin
            restore_valid     <= return_from_irq_instr && (state_r == irq_pkg::ST_SERVICE);
            acc_restore       <= acc_shadow_r;
            work_regs_restore <= work_shadow_r;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= irq_pkg::ZERO_BYTE;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                irq_pkg::ADDR_FLAGS:    reg_rdata <= flags_r;
                irq_pkg::ADDR_ENABLES:  reg_rdata <= enable_r;
                irq_pkg::ADDR_EDGE_SEL: reg_rdata <= {4'h0, edge_sel_r};
                irq_pkg::ADDR_GLOBAL:   reg_rdata <= {global_r, 7'h00};
                irq_pkg::ADDR_SHADOW:   reg_rdata <= acc_shadow_r;
                default:                reg_rdata <= irq_pkg::ZERO_BYTE;
            endcase
        end else begin
            reg_rdata <= irq_pkg::ZERO_BYTE;
        end
    end
endmodule : ext_edge_and_periph_irq_logic
`default_nettype wire

// ==== src/irq_pkg.sv ====
// Package with register map, field positions, vectors and types of the interrupt logic.
package irq_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_FLAGS     = 8'h97;
    localparam logic [7:0] ADDR_ENABLES   = 8'h9A;
    localparam logic [7:0] ADDR_EDGE_SEL  = 8'h9F;
    localparam logic [7:0] ADDR_GLOBAL    = 8'hEF;
    localparam logic [7:0] ADDR_SHADOW    = 8'hE0;
    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [3:0] EDGE_SEL_RESET = 4'hA;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;
    localparam logic [7:0] ENABLE_RESET   = 8'h00;
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam int         GLOBAL_BIT     = 7;
    localparam int         NUM_SRC        = 8;
    localparam int         SRC_PIN_A      = 0;
    localparam int         SRC_PIN_B      = 1;
    localparam int         SRC_BASIC      = 2;
    localparam int         SRC_TMR_A      = 3;
    localparam int         SRC_TMR_B      = 4;
    localparam int         SRC_TMR_C      = 5;
    localparam int         SRC_WIDE       = 6;
    localparam int         SRC_CONV       = 7;
    localparam int         NUM_WORK_REGS  = 16;
    // ****************************************
    // Vector addresses
    // ****************************************
    localparam logic [15:0] VEC_PIN_A     = 16'h0009;
    localparam logic [15:0] VEC_PIN_B     = 16'h000A;
    localparam logic [15:0] VEC_BASIC     = 16'h000B;
    localparam logic [15:0] VEC_TMR_A     = 16'h000C;
    localparam logic [15:0] VEC_TMR_B     = 16'h000D;
    localparam logic [15:0] VEC_TMR_C     = 16'h000E;
    localparam logic [15:0] VEC_WIDE      = 16'h000F;
    localparam logic [15:0] VEC_CONV      = 16'h0010;
    localparam logic [15:0] VEC_NONE      = 16'h0000;
    // ****************************************
    // Edge selection codes and service state codes
    // ****************************************
    typedef enum logic [1:0] {
        EDGE_RESERVED = 2'b00,
        EDGE_RISING   = 2'b01,
        EDGE_FALLING  = 2'b10,
        EDGE_BOTH     = 2'b11
    } edge_sel_t;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAVE    = 2'b01,
        ST_SERVICE = 2'b10
    } irq_state_t;
    // Peripheral event strobes, one cycle each.
    typedef struct packed {
        logic basic_timer_ovf;
        logic tmr_a_ovf;
        logic tmr_b_ovf;
        logic tmr_c_ovf;
        logic wide_timer_ovf;
        logic converter_done;
    } periph_events_t;
    // Register port of the CPU.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;
    // Vector request towards the CPU.
    typedef struct packed {
        logic        take;
        logic [15:0] vector;
        logic [2:0]  source;
    } vec_out_t;
endpackage : irq_pkg

// ==== testbench/irq_logic_chk.sv ====
// Port-level assertions of the interrupt logic.
`timescale 1ns/10ps
`default_nettype none
module irq_logic_chk (
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              power_down,
    input wire irq_pkg::reg_req_t reg_req,
    input wire logic [7:0]        reg_rdata,
    input wire logic              return_from_irq_instr,
    input wire irq_pkg::vec_out_t vec_out,
    input wire logic              stack_push,
    input wire logic              restore_valid
);
    logic [7:0] en_r, en_d1_r, en_d2_r;
    logic       gl_r, gl_d1_r, gl_d2_r;
    // ****************************************
    // Enable shadow delayed to the eligible cycle
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {en_r, en_d1_r, en_d2_r} <= 24'h000000;
            {gl_r, gl_d1_r, gl_d2_r} <= 3'h0;
        end else begin
            if (reg_req.wr && reg_req.addr == irq_pkg::ADDR_ENABLES) begin
                en_r <= reg_req.wdata;
            end
            if (reg_req.wr && reg_req.addr == irq_pkg::ADDR_GLOBAL) begin
                gl_r <= reg_req.wdata[irq_pkg::GLOBAL_BIT];
            end
            {en_d2_r, en_d1_r} <= {en_d1_r, en_r};
            {gl_d2_r, gl_d1_r} <= {gl_d1_r, gl_r};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ****************************************
    // Properties
    // ****************************************
    property p_take_once;
        vec_out.take |=> !vec_out.take ##1 !vec_out.take;
    endproperty
    property p_push;
        stack_push == vec_out.take;
    endproperty
    property p_vec_map;
        vec_out.take |-> vec_out.vector == 16'h0009 + {13'h0000, vec_out.source};
    endproperty
    property p_vec_idle;
        !vec_out.take |-> vec_out.vector == irq_pkg::VEC_NONE;
    endproperty
    property p_global;
        vec_out.take |-> gl_d2_r;
    endproperty
    property p_enable;
        vec_out.take |-> en_d2_r[vec_out.source];
    endproperty
    property p_sleep;
        power_down && $past(power_down) && $past(power_down, 2) |-> !vec_out.take;
    endproperty
    property p_restore;
        restore_valid |-> $past(return_from_irq_instr) ##1 !restore_valid;
    endproperty
    property p_edge_read;
        $past(reg_req.rd) && $past(reg_req.addr) == irq_pkg::ADDR_EDGE_SEL
            |-> reg_rdata[7:4] == 4'h0;
    endproperty
    a_take_once: assert property (p_take_once) else $error("take not single");
    a_push: assert property (p_push) else $error("stack push apart from take");
    a_vec_map: assert property (p_vec_map) else $error("vector off source");
    a_vec_idle: assert property (p_vec_idle) else $error("vector without take");
    a_global: assert property (p_global) else $error("take with global off");
    a_enable: assert property (p_enable) else $error("take with enable off");
    a_sleep: assert property (p_sleep) else $error("take in power down");
    a_restore: assert property (p_restore) else $error("restore not after return");
    a_edge_read: assert property (p_edge_read) else $error("edge select high bits");
    c_pin: cover property (vec_out.take && vec_out.vector == 16'h0009);
    c_conv: cover property (vec_out.take && vec_out.vector == 16'h0010);
    c_restore: cover property (restore_valid);
endmodule : irq_logic_chk
bind ext_edge_and_periph_irq_logic irq_logic_chk irq_logic_chk_i (
    .clk(clk), .sys_rst(sys_rst), .power_down(power_down), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .return_from_irq_instr(return_from_irq_instr),
    .vec_out(vec_out), .stack_push(stack_push), .restore_valid(restore_valid));
`default_nettype wire

// ==== testbench/irq_cpu_model.sv ====
// Core model: live context, service delay and return from interrupt.
`timescale 1ns/10ps
`default_nettype none
module irq_cpu_model (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire irq_pkg::vec_out_t vec_out,
    input  wire logic              slow,
    output logic                   return_from_irq_instr,
    output logic [7:0]             acc_in,
    output logic [127:0]           work_regs_in,
    output logic [7:0]             exp_acc
);
    logic [7:0] cnt_r;
    logic [3:0] wait_r;
    logic       busy_r;
    // Context moves every cycle, so a save at the wrong edge shows up.
    assign acc_in       = cnt_r;
    assign work_regs_in = {16{cnt_r ^ 8'h5A}};
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {cnt_r, exp_acc, wait_r, busy_r, return_from_irq_instr} <= 22'h000000;
        end else begin
            cnt_r                 <= cnt_r + 8'h01;
            return_from_irq_instr <= 1'b0;
            if (vec_out.take) begin
                busy_r  <= 1'b1;
                wait_r  <= slow ? 4'hC : 4'h1;
                exp_acc <= cnt_r - 8'h02;
            end else if (busy_r) begin
                wait_r <= wait_r - 4'h1;
                if (wait_r == 4'h1) begin
                    busy_r                <= 1'b0;
                    return_from_irq_instr <= 1'b1;
                end
            end
        end
    end
endmodule : irq_cpu_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Register-level testbench of the interrupt logic.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                    clk, sys_rst, ext_irq_pin_a, ext_irq_pin_b, power_down, slow;
    irq_pkg::periph_events_t events;
    irq_pkg::reg_req_t       reg_req;
    irq_pkg::vec_out_t       vec_out;
    logic [7:0]              reg_rdata, acc_in, acc_restore, exp_acc;
    logic [127:0]            work_regs_in, work_regs_restore;
    logic                    return_from_irq_instr, stack_push, restore_valid, wake_request;
    int                      err_total, compares;
    ext_edge_and_periph_irq_logic ext_edge_and_periph_irq_logic_i (.clk(clk),
        .sys_rst(sys_rst), .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
        .power_down(power_down), .events(events), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .return_from_irq_instr(return_from_irq_instr), .acc_in(acc_in),
        .work_regs_in(work_regs_in), .vec_out(vec_out), .stack_push(stack_push),
        .restore_valid(restore_valid), .acc_restore(acc_restore),
        .work_regs_restore(work_regs_restore), .wake_request(wake_request));
    irq_cpu_model irq_cpu_model_i (.clk(clk), .sys_rst(sys_rst), .vec_out(vec_out),
        .slow(slow), .return_from_irq_instr(return_from_irq_instr), .acc_in(acc_in),
        .work_regs_in(work_regs_in), .exp_acc(exp_acc));
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req <= '0;
        @(posedge clk);
        chk(128'(reg_rdata), 128'(exp));
    endtask : rd
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        events <= m;
        @(posedge clk);
        events <= '0;
    endtask : pulse
    task automatic take_is(input logic [15:0] v);
        int n;
        n = 0;
        @(posedge clk);
        while (vec_out.take !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(128'(vec_out.vector), 128'(v));
    endtask : take_is
    task automatic no_take(input int n);
        int seen;
        seen = 0;
        repeat (n) begin
            @(posedge clk);
            if (vec_out.take !== 1'b0) seen++;
        end
        chk(128'(seen), 128'h0);
    endtask : no_take
    task automatic pin(input int p, input logic v);
        @(posedge clk);
        if (p == 1) ext_irq_pin_b <= v;
        else ext_irq_pin_a <= v;
        repeat (4) @(posedge clk);
    endtask : pin
    task automatic test_done;
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        if (restore_valid === 1'b1) begin
            chk(128'(acc_restore), 128'(exp_acc));
            chk(work_regs_restore, {16{exp_acc ^ 8'h5A}});
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // The whole sequence needs well under two thousand cycles.
    initial begin
        #(25 * 5000);
        err_total++;
        test_done();
    end
    initial begin
        logic [7:0] bit_m;
        int         n;
        {sys_rst, ext_irq_pin_a, ext_irq_pin_b, power_down, slow} = 5'h10;
        events  = '0;
        reg_req = '0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h97, 8'h00);
        rd(8'h9A, 8'h00);
        rd(8'h9F, 8'h0A);
        rd(8'hEF, 8'h00);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        wr(8'hEF, 8'h80);
        pulse(6'h3F);
        rd(8'h97, 8'hFC);
        no_take(10);
        wr(8'h9A, 8'hFC);
        no_take(10);
        wr(8'h97, 8'hF4);
        rd(8'h97, 8'hF4);
        wr(8'h97, 8'h00);
        rd(8'h97, 8'h00);
        slow <= 1'b1;
        pulse(6'h3F);
        take_is(16'h000B);
        rd(8'h97, 8'hF8);
        for (n = 1; n < 6; n++) take_is(16'h000B + 16'(n));
        slow <= 1'b0;
        wr(8'hEF, 8'h00);
        pulse(6'h10);
        no_take(10);
        wr(8'hEF, 8'h80);
        take_is(16'h000C);
        wr(8'hEF, 8'h00);
        wr(8'h9A, 8'h03);
        for (n = 0; n < 6; n++) begin
            bit_m = 8'h01 << (n / 3);
            wr(8'h9F, 8'((n % 3) + 1) << (2 * (n / 3)));
            pin(n / 3, 1'b1);
            rd(8'h97, ((n % 3) != 1) ? bit_m : 8'h00);
            wr(8'h97, 8'h00);
            pin(n / 3, 1'b0);
            rd(8'h97, ((n % 3) != 0) ? bit_m : 8'h00);
            wr(8'h97, 8'h00);
        end
        wr(8'h9A, 8'h00);
        wr(8'h9F, 8'h0F);
        pin(0, 1'b1);
        rd(8'h97, 8'h00);
        pin(0, 1'b0);
        wr(8'h9A, 8'h03);
        wr(8'h9F, 8'h05);
        wr(8'hEF, 8'h80);
        pin(0, 1'b1);
        take_is(16'h0009);
        pin(1, 1'b1);
        take_is(16'h000A);
        {ext_irq_pin_a, ext_irq_pin_b, power_down} <= 3'h1;
        pin(0, 1'b0);
        pin(0, 1'b1);
        chk(128'(wake_request), 128'h1);
        no_take(8);
        power_down <= 1'b0;
        take_is(16'h0009);
        repeat (20) @(posedge clk);
        test_done();
    end
endmodule : tb
`default_nettype wire
